// File: core/pwl_pkg.sv
/*
 * Shared constants for the pulse-width limit and telemetry link.
 * Assumes a single 40 MHz core clock on both ends.
 */
// Functional notes
// [R1] telemetry report opens with 900 us start pulse
// [R2] telemetry bits: 500 us zero, 750 us one
// [R3] eight data pulses carry 8-bit power code
// [R4] open config input means power-limiting mode
// [R5] grounded config input means current-limiting mode
// [R6] no pulses keeps power mode until current frame
// [R7] controller pulses: 1000 us period, 500/750 high
// [R8] frame is two signature then eight data pulses
// [R9] controller idles at least 22 ms between frames
// [R10] signature zero-then-one selects power mode, level
// [R11] signature one-then-zero selects current mode, level
// [R12] mode change only while limiting loop inactive
// [R13] decoded level replaces classification limit as reference
// [R14] new decoded level replaces earlier stored level
// [R15] after power-up use classification level until frame
// [R16] limiting enabled 1.2 ms after switch enhanced
// [R17] classify high time with tolerance, discard bad frames
// [R18] data bits sent and received MSB first
package pwl_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int PERIOD_US = 1000;
    localparam int HI_ZERO_US = 500;
    localparam int HI_ONE_US = 750;
    localparam int HI_START_US = 900;
    localparam int TOL_US = 100;
    localparam int GAP_US = 22_000;
    localparam int EN_DELAY_US = 1200;

    function automatic int us_cyc(input int us);
        us_cyc = (us * (CLK_HZ / 1_000_000));
    endfunction

    localparam int PERIOD_CYC = us_cyc(PERIOD_US);
    localparam int ZERO_CYC = us_cyc(HI_ZERO_US);
    localparam int ONE_CYC = us_cyc(HI_ONE_US);
    localparam int START_CYC = us_cyc(HI_START_US);
    localparam int TOL_CYC = us_cyc(TOL_US);
    localparam int GAP_CYC = us_cyc(GAP_US);
    localparam int EN_DELAY_CYC = us_cyc(EN_DELAY_US);

    localparam int CNT_W = 20;
    localparam int DATA_BITS = 8;
    localparam int SIG_PULSES = 2;
    localparam logic [3:0] FRAME_PULSES = 4'hA;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [1:0] {
        PWL_MODE_POWER = 2'h1,
        PWL_MODE_CURRENT = 2'h2
    } pwl_mode_t;
endpackage

// File: core/pwl_link_if.sv
/*
 * Interface joining the device and controller ends.
 * Holds the configuration wire and the telemetry wire; an undriven
 * configuration wire floats high, as the pin does with no controller.
 */
`timescale 1ns/10ps
`default_nettype none
interface pwl_link_if;
    logic cfg_out;
    logic cfg_oe;
    logic cfg_strap_gnd;
    logic telem;
    wire cfg_level = cfg_strap_gnd ? 1'b0 : (cfg_oe ? cfg_out : 1'b1);

    modport device (input cfg_level, output telem);
    modport host (output cfg_out, output cfg_oe, input telem);
endinterface
`default_nettype wire

// File: core/pwl_pulse_tx.sv
/*
 * Pulse-width serialiser used by both ends: one start pulse or two signature
 * pulses, then eight data pulses MSB first, each on a fixed period.
 * Assumes start is a single-cycle request taken only while idle.
 */
`timescale 1ns/10ps
`default_nettype none
module pwl_pulse_tx
    import pwl_pkg::*;
#(
    // divides every time count; only a bench runs anything but 1
    parameter int TIME_DIV = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // request
    input wire logic start,
    input wire logic [1:0] lead_bits,
    input wire logic lead_is_start,
    input wire logic [7:0] data,
    output logic busy,
    // line
    output logic line_out
);
    logic [CNT_W-1:0] cnt_reg;
    logic [3:0] idx_reg;
    logic [9:0] shift_reg;
    logic [CNT_W-1:0] hi_len;
    logic [3:0] n_pulses;
    logic start_mode_reg;
    localparam int PER_C = PERIOD_CYC / TIME_DIV;
    localparam int ZERO_C = ZERO_CYC / TIME_DIV;
    localparam int ONE_C = ONE_CYC / TIME_DIV;
    localparam int START_C = START_CYC / TIME_DIV;

    // telemetry has one lead pulse, config frames two signature pulses
    assign n_pulses = start_mode_reg ? 4'(DATA_BITS + 1) : FRAME_PULSES;

    always_comb begin
        if (start_mode_reg && idx_reg == 4'h0) begin
            hi_len = CNT_W'(START_C); // R1
        end else begin
            hi_len = shift_reg[9] ? CNT_W'(ONE_C) : CNT_W'(ZERO_C); // R2
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy <= 1'b0;
            cnt_reg <= '0;
            idx_reg <= '0;
            shift_reg <= '0;
            start_mode_reg <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                cnt_reg <= '0;
                idx_reg <= '0;
                start_mode_reg <= lead_is_start;
                // msb leads; telemetry start pulse shifts nothing out
                shift_reg <= lead_is_start ? {data, 2'h0}
                                           : {lead_bits, data}; // R18
            end
        end else if (cnt_reg == CNT_W'(PER_C - 1)) begin
            cnt_reg <= '0;
            if (!(start_mode_reg && idx_reg == 4'h0)) begin
                shift_reg <= {shift_reg[8:0], 1'b0};
            end
            if (idx_reg == n_pulses - 4'h1) begin
                busy <= 1'b0; // R3
            end
            idx_reg <= idx_reg + 4'h1;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            line_out <= 1'b0;
        end else begin
            line_out <= busy && (cnt_reg < hi_len);
        end
    end
endmodule
`default_nettype wire

// File: core/pwl_host.sv
/*
 * Controller end: sends limit-configuration frames and decodes nothing.
 * Enforces the inter-frame gap itself so callers need not.
 */
`timescale 1ns/10ps
`default_nettype none
module pwl_host
    import pwl_pkg::*;
#(
    // divides every time count; only a bench runs anything but 1
    parameter int TIME_DIV = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // link
    pwl_link_if.host link,
    // user request
    input wire logic cfg_valid,
    input wire logic cfg_current_mode,
    input wire logic [7:0] cfg_level_in,
    output logic cfg_ready,
    // raw telemetry line, synchronised
    output logic telem_sync
);
    logic busy;
    logic tx_line;
    logic [CNT_W-1:0] gap_reg;
    logic t_meta_reg;
    logic start;

    assign cfg_ready = !busy && gap_reg == '0; // R9
    assign start = cfg_valid && cfg_ready;

    pwl_pulse_tx #(.TIME_DIV(TIME_DIV)) u_tx (
        .core_clk(core_clk),
        .reset(reset),
        .start(start),
        // R10 R11 R7
        .lead_bits(cfg_current_mode ? 2'h2 : 2'h1),
        .lead_is_start(1'b0),
        .data(cfg_level_in),
        .busy(busy),
        .line_out(tx_line)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            gap_reg <= '0;
        end else if (busy) begin
            gap_reg <= CNT_W'(GAP_CYC / TIME_DIV); // R9
        end else if (gap_reg != '0) begin
            gap_reg <= gap_reg - CNT_W'(1);
        end
    end

    assign link.cfg_out = tx_line;
    // leaving the wire released between frames reads as open
    assign link.cfg_oe = busy;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            t_meta_reg <= 1'b0;
            telem_sync <= 1'b0;
        end else begin
            t_meta_reg <= link.telem;
            telem_sync <= t_meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: core/pwl_device.sv
/*
 * Powered-device end: decodes configuration frames, keeps mode and
 * level, gates limiting after switch enhancement, sends telemetry.
 * Assumes class_level, loop_active, switch_enhanced, power_code are
 * on core_clk; the configuration line comes from a pin.
 */
`timescale 1ns/10ps
`default_nettype none
module pwl_device
    import pwl_pkg::*;
#(
    // divides every time count; only a bench runs anything but 1
    parameter int TIME_DIV = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // link
    pwl_link_if.device link,
    // analog-side status
    input wire logic [7:0] class_level,
    input wire logic loop_active,
    input wire logic switch_enhanced,
    input wire logic [7:0] power_code,
    input wire logic telem_req,
    // limit outputs
    output pwl_mode_t limit_mode,
    output logic [7:0] limit_ref,
    output logic limit_enable,
    output logic telem_busy
);
    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_HIGH = 3'h2,
        RX_LOW = 3'h4
    } pwl_rx_t;

    pwl_rx_t rx_state_reg;
    logic meta_reg, line_reg, line_d_reg;
    logic [CNT_W-1:0] hi_reg, per_reg, idle_reg, en_cnt_reg;
    logic [3:0] pcount_reg;
    logic [9:0] bits_reg;
    logic frame_ok_reg, have_frame_reg, level_valid_reg;
    logic [7:0] lvl_reg;
    logic pend_reg;
    pwl_mode_t pend_mode_reg;
    logic low_seen_reg;
    logic tx_line, tx_start;
    localparam int PER_C = PERIOD_CYC / TIME_DIV;
    localparam int ZERO_C = ZERO_CYC / TIME_DIV;
    localparam int ONE_C = ONE_CYC / TIME_DIV;
    localparam int TOL_C = TOL_CYC / TIME_DIV;
    localparam int IDLE_C = PER_C * 2;
    localparam int EN_C = EN_DELAY_CYC / TIME_DIV;

    function automatic logic near(input logic [CNT_W-1:0] v,
                                  input int target);
        near = (v + CNT_W'(TOL_C) >= CNT_W'(target)) &&
               (v <= CNT_W'(target + TOL_C));
    endfunction

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_reg <= 1'b1;
            line_reg <= 1'b1;
            line_d_reg <= 1'b1;
        end else begin
            meta_reg <= link.cfg_level;
            line_reg <= meta_reg;
            line_d_reg <= line_reg;
        end
    end

    // a long-held level ends or aborts any frame in progress
    always_ff @(posedge core_clk) begin
        if (reset || line_reg != line_d_reg) begin
            idle_reg <= '0;
        end else if (idle_reg != CNT_W'(IDLE_C)) begin
            idle_reg <= idle_reg + CNT_W'(1);
        end
    end

    // R17: measure each pulse, check high time and period
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_state_reg <= RX_IDLE;
            hi_reg <= '0;
            per_reg <= '0;
            pcount_reg <= '0;
            bits_reg <= '0;
            frame_ok_reg <= 1'b0;
            have_frame_reg <= 1'b0;
        end else begin
            have_frame_reg <= 1'b0;
            case (rx_state_reg)
                RX_IDLE: begin
                    if (line_reg && !line_d_reg) begin
                        rx_state_reg <= RX_HIGH;
                        hi_reg <= CNT_W'(1);
                        per_reg <= CNT_W'(1);
                        pcount_reg <= '0;
                        frame_ok_reg <= 1'b1;
                    end
                end
                RX_HIGH: begin
                    per_reg <= per_reg + CNT_W'(1);
                    if (idle_reg == CNT_W'(IDLE_C)) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (line_reg) begin
                        hi_reg <= hi_reg + CNT_W'(1);
                    end else begin
                        rx_state_reg <= RX_LOW;
                        if (!near(hi_reg, ZERO_C) &&
                            !near(hi_reg, ONE_C)) begin
                            frame_ok_reg <= 1'b0; // R17
                        end
                        // R18 R8
                        bits_reg <= {bits_reg[8:0], near(hi_reg, ONE_C)};
                        pcount_reg <= pcount_reg + 4'h1;
                    end
                end
                RX_LOW: begin
                    per_reg <= per_reg + CNT_W'(1);
                    if (line_reg && !line_d_reg) begin
                        if (!near(per_reg, PER_C)) begin
                            rx_state_reg <= RX_IDLE; // R17
                        end else begin
                            rx_state_reg <= RX_HIGH;
                            hi_reg <= CNT_W'(1);
                            per_reg <= CNT_W'(1);
                        end
                    end else if (pcount_reg == FRAME_PULSES &&
                                 per_reg >= CNT_W'(PER_C - TOL_C)) begin
                        rx_state_reg <= RX_IDLE;
                        have_frame_reg <= frame_ok_reg; // R8
                    end else if (idle_reg == CNT_W'(IDLE_C)) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // strap sense: low for a full idle window with no frame means ground
    always_ff @(posedge core_clk) begin
        if (reset) begin
            low_seen_reg <= 1'b0;
        end else if (idle_reg == CNT_W'(IDLE_C)) begin
            low_seen_reg <= !line_reg; // R4 R5 R6
        end
    end

    // R13 R14 R15: level held in mode-neutral register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            level_valid_reg <= 1'b0; // R15
            lvl_reg <= '0;
        end else if (have_frame_reg &&
                     (bits_reg[9:8] == 2'h1 || bits_reg[9:8] == 2'h2)) begin
            level_valid_reg <= 1'b1; // R13
            lvl_reg <= bits_reg[7:0]; // R14
        end
    end

    // R12: mode request waits until the loop is idle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_reg <= 1'b0;
            pend_mode_reg <= PWL_MODE_POWER;
        end else if (have_frame_reg && bits_reg[9:8] == 2'h1) begin
            pend_reg <= 1'b1; // R10
            pend_mode_reg <= PWL_MODE_POWER;
        end else if (have_frame_reg && bits_reg[9:8] == 2'h2) begin
            pend_reg <= 1'b1; // R11
            pend_mode_reg <= PWL_MODE_CURRENT;
        end else if (!loop_active) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            limit_mode <= PWL_MODE_POWER; // R4 R6
        end else if (!loop_active) begin
            if (pend_reg) begin
                limit_mode <= pend_mode_reg; // R12
            end else if (!level_valid_reg) begin
                limit_mode <= low_seen_reg ? PWL_MODE_CURRENT
                                           : PWL_MODE_POWER; // R5
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            limit_ref <= '0;
        end else begin
            limit_ref <= level_valid_reg ? lvl_reg : class_level; // R13 R15
        end
    end

    // R16: enable delay restarts whenever the switch drops
    always_ff @(posedge core_clk) begin
        if (reset || !switch_enhanced) begin
            en_cnt_reg <= '0;
            limit_enable <= 1'b0;
        end else if (en_cnt_reg == CNT_W'(EN_C - 1)) begin
            limit_enable <= 1'b1; // R16
        end else begin
            en_cnt_reg <= en_cnt_reg + CNT_W'(1);
        end
    end

    assign tx_start = telem_req && !telem_busy;

    pwl_pulse_tx #(.TIME_DIV(TIME_DIV)) u_tx (
        .core_clk(core_clk),
        .reset(reset),
        .start(tx_start),
        .lead_bits(2'h0),
        .lead_is_start(1'b1), // R1
        .data(power_code), // R3
        .busy(telem_busy),
        .line_out(tx_line)
    );

    assign link.telem = tx_line;
endmodule
`default_nettype wire

// File: verification/pwl_link_sva.sv
/*
 * Wire-level checker for the configuration and telemetry link.
 * Assumes it sits beside the interface and sees only its signals.
 */
`timescale 1ns/10ps
`default_nettype none
module pwl_link_sva
    import pwl_pkg::*;
#(
    parameter int TIME_DIV = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // link wires
    input wire logic cfg_out,
    input wire logic cfg_oe,
    input wire logic telem
);
    localparam int PER_C = PERIOD_CYC / TIME_DIV;
    localparam int ZERO_C = ZERO_CYC / TIME_DIV;
    localparam int ONE_C = ONE_CYC / TIME_DIV;
    localparam int START_C = START_CYC / TIME_DIV;
    localparam int GAP_C = GAP_CYC / TIME_DIV;
    logic cfg_drv, cfg_prev, tel_prev, sent;
    int cfg_hi, cfg_per, cfg_np, oe_cnt, gap_cnt;
    int tel_hi, tel_lo, tel_per, tel_np;
    assign cfg_drv = cfg_oe & cfg_out;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_prev <= 1'b0;
            sent <= 1'b0;
            cfg_hi <= 0;
            cfg_per <= 0;
            cfg_np <= 0;
            oe_cnt <= 0;
            gap_cnt <= 0;
        end else begin
            cfg_prev <= cfg_drv;
            cfg_hi <= cfg_drv ? cfg_hi + 1 : 0;
            cfg_per <= (cfg_drv && !cfg_prev) ? 1 : cfg_per + 1;
            oe_cnt <= cfg_oe ? oe_cnt + 1 : 0;
            gap_cnt <= cfg_oe ? 0 : gap_cnt + 1;
            if (cfg_oe) sent <= 1'b1;
            if (!cfg_oe) cfg_np <= 0;
            else if (cfg_drv && !cfg_prev) cfg_np <= cfg_np + 1;
        end
    end

    // a long low run or the ninth pulse ends a report, so back-to-back ones split
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tel_prev <= 1'b0;
            tel_hi <= 0;
            tel_lo <= 0;
            tel_per <= 0;
            tel_np <= 0;
        end else begin
            tel_prev <= telem;
            tel_hi <= telem ? tel_hi + 1 : 0;
            tel_lo <= telem ? 0 : tel_lo + 1;
            tel_per <= (telem && !tel_prev) ? 1 : tel_per + 1;
            if (tel_lo >= PER_C) tel_np <= 0;
            else if (!telem && tel_prev)
                tel_np <= (tel_np == DATA_BITS) ? 0 : tel_np + 1;
        end
    end

    sequence cfg_rise;
        cfg_drv && !cfg_prev;
    endsequence
    sequence tel_rise;
        telem && !tel_prev;
    endsequence
    sequence tel_fall;
        !telem && tel_prev;
    endsequence

    chk_reset_idle: assert property (
        disable iff (1'b0) reset |=> !cfg_oe && !telem)
        else $error("link wires not idle after reset");
    chk_cfg_width: assert property (
        $fell(cfg_drv) |-> cfg_hi == ZERO_C || cfg_hi == ONE_C)
        else $error("config pulse width off");
    chk_cfg_period: assert property (
        cfg_rise ##0 (cfg_np != 0) |-> cfg_per == PER_C)
        else $error("config pulse period off");
    chk_cfg_count: assert property (
        $fell(cfg_oe) |-> cfg_np == FRAME_PULSES)
        else $error("config frame pulse count off");
    chk_cfg_span: assert property (
        $fell(cfg_oe) |-> oe_cnt == PER_C * FRAME_PULSES)
        else $error("config frame length off");
    chk_cfg_gap: assert property (
        $rose(cfg_oe) && sent |-> gap_cnt >= GAP_C)
        else $error("config frames too close");
    chk_tel_start: assert property (
        tel_fall ##0 (tel_np == 0) |-> tel_hi == START_C)
        else $error("telemetry start width off");
    chk_tel_bits: assert property (
        tel_fall ##0 (tel_np != 0) |-> tel_hi == ZERO_C || tel_hi == ONE_C)
        else $error("telemetry bit width off");
    chk_tel_period: assert property (
        tel_rise ##0 (tel_np != 0) |-> tel_per == PER_C)
        else $error("telemetry period off");
    chk_tel_count: assert property (
        tel_lo == PER_C |-> tel_np == 0)
        else $error("telemetry pulse count off");
endmodule
`default_nettype wire

// File: verification/testbench.sv
/*
 * Testbench joining device and controller ends through the interface.
 * Assumes both ends run with time counts divided by TDIV; about 60k cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pwl_pkg::*;
;
    // one clock per microsecond keeps the run short
    localparam int TDIV = 40;
    logic core_clk, reset, loop_active, switch_enhanced, telem_req;
    logic telem_sync;
    logic cfg_valid, cfg_current_mode, cfg_ready, limit_enable, telem_busy;
    logic [7:0] class_level, power_code, cfg_level_in, limit_ref;
    pwl_mode_t limit_mode;
    int fails, checked;
    pwl_link_if lnk();

    pwl_device #(.TIME_DIV(TDIV)) pwl_device_i (.core_clk(core_clk),
        .reset(reset), .link(lnk),
        .class_level(class_level), .loop_active(loop_active),
        .switch_enhanced(switch_enhanced), .power_code(power_code),
        .telem_req(telem_req), .limit_mode(limit_mode),
        .limit_ref(limit_ref), .limit_enable(limit_enable),
        .telem_busy(telem_busy));
    pwl_host #(.TIME_DIV(TDIV)) pwl_host_i (.core_clk(core_clk),
        .reset(reset), .link(lnk),
        .cfg_valid(cfg_valid), .cfg_current_mode(cfg_current_mode),
        .cfg_level_in(cfg_level_in), .cfg_ready(cfg_ready),
        .telem_sync(telem_sync));
    pwl_link_sva #(.TIME_DIV(TDIV)) pwl_link_sva_i (.core_clk(core_clk),
        .reset(reset),
        .cfg_out(lnk.cfg_out), .cfg_oe(lnk.cfg_oe), .telem(lnk.telem));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic t_reset();
        repeat (3) @(negedge core_clk);
        check("mode", PWL_MODE_POWER, limit_mode);
        check("level", 8'h5A, limit_ref);
        check("enable", 1'b0, limit_enable);
        $display("test reset done");
    endtask

    task automatic t_enable();
        switch_enhanced = 1'b1;
        repeat (EN_DELAY_CYC / TDIV - 1) @(negedge core_clk);
        check("early enable", 1'b0, limit_enable);
        repeat (2) @(negedge core_clk);
        check("enable", 1'b1, limit_enable);
        switch_enhanced = 1'b0;
        repeat (5) @(negedge core_clk);
        check("enable off", 1'b0, limit_enable);
        $display("test enable done");
    endtask

    // widths are counted in falling-edge samples of the host's copy
    task automatic t_telem();
        int n, w;
        logic [7:0] got;
        got = 8'h00;
        power_code = 8'h6B;
        telem_req = 1'b1;
        @(negedge core_clk);
        telem_req = 1'b0;
        for (int p = 0; p < 9; p++) begin
            n = 0;
            while (telem_sync !== 1'b1 && n < 50000) begin
                @(negedge core_clk);
                n++;
            end
            w = 0;
            while (telem_sync === 1'b1 && w < 50000) begin
                @(negedge core_clk);
                w++;
            end
            if (p == 0) check("start width", START_CYC / TDIV, w);
            else begin
                got = {got[6:0], (w == ONE_CYC / TDIV)};
                if (w != ONE_CYC / TDIV) begin
                    check("bit width", ZERO_CYC / TDIV, w);
                end
            end
        end
        check("telemetry code", 8'h6B, got);
        $display("test telemetry done");
    endtask

    task automatic t_strap();
        loop_active = 1'b0;
        lnk.cfg_strap_gnd = 1'b1;
        repeat (2 * PERIOD_CYC / TDIV + 20) @(negedge core_clk);
        check("strap mode", PWL_MODE_CURRENT, limit_mode);
        lnk.cfg_strap_gnd = 1'b0;
        // the release edge must time out in the receiver before a frame
        repeat (2 * PERIOD_CYC / TDIV + 20) @(negedge core_clk);
        check("open mode", PWL_MODE_POWER, limit_mode);
        $display("test strap done");
    endtask

    task automatic send_frame(input logic cur, input logic [7:0] lvl);
        int n;
        n = 0;
        while (cfg_ready !== 1'b1 && n < 1000000) begin
            @(negedge core_clk);
            n++;
        end
        cfg_current_mode = cur;
        cfg_level_in = lvl;
        cfg_valid = 1'b1;
        @(negedge core_clk);
        cfg_valid = 1'b0;
        n = 0;
        while (limit_ref !== lvl && n < 500000) begin
            @(negedge core_clk);
            n++;
        end
        check("limit level", lvl, limit_ref);
        repeat (5) @(negedge core_clk);
    endtask

    task automatic t_power();
        send_frame(1'b0, 8'h1D);
        check("power mode", PWL_MODE_POWER, limit_mode);
        $display("test power frame done");
    endtask

    task automatic t_current();
        loop_active = 1'b1;
        send_frame(1'b1, 8'hE4);
        check("withheld mode", PWL_MODE_POWER, limit_mode);
        loop_active = 1'b0;
        repeat (5) @(negedge core_clk);
        check("current mode", PWL_MODE_CURRENT, limit_mode);
        $display("test current frame done");
    endtask

    // cut-off allows two frames, the gap between them and one report
    initial begin
        #2_000_000;
        fails++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        loop_active = 1'b0;
        switch_enhanced = 1'b0;
        telem_req = 1'b0;
        cfg_valid = 1'b0;
        cfg_current_mode = 1'b0;
        class_level = 8'h5A;
        power_code = 8'h00;
        cfg_level_in = 8'h00;
        lnk.cfg_strap_gnd = 1'b0;
        fails = 0;
        checked = 0;
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        t_reset();
        t_enable();
        t_telem();
        t_strap();
        t_current();
        t_power();
        give_verdict();
    end
endmodule
`default_nettype wire
